// ### rtl/cmd_priv_regs.svh
/*
  constants for the command privilege filter: offsets, masks, counts.
  assumes inclusion by bare name from design and bench files.
*/
`ifndef CMD_PRIV_REGS_SVH
`define CMD_PRIV_REGS_SVH

`define PERF_OBS_CTRL_OFFS 23'h002B00
`define PWL_ENTRIES 12
`define REG_OFFS_W 23
`define ENGINE_MMIO_BASE 23'h002000
`define ENGINE_MMIO_MASK 23'h7FF000
`define ARB_UNIT_BASE 23'h004000
`define ARB_UNIT_MASK 23'h7FF000
`define DISPLAY_BASE 23'h060000
`define DISPLAY_MASK 23'h7E0000
`define HW_WL_0 23'h002358
`define HW_WL_1 23'h002B00
`define HW_WL_2 23'h0024D0
`define HW_WL_3 23'h0024D4

`endif

// ### rtl/cmd_priv_pkg.sv
/*
  types shared by the privilege filter, the command source model and the bench.
  assumes the constants header is included where offsets are needed.
*/
package cmd_priv_pkg;
  typedef enum logic [4:0] {
    op_noop = 5'h00,
    op_batch_jump = 5'h01,
    op_reg_load_imm = 5'h02,
    op_reg_load_reg = 5'h03,
    op_reg_load_mem = 5'h04,
    op_reg_store_mem = 5'h05,
    op_indexed_store = 5'h06,
    op_store_imm = 5'h07,
    op_semaphore = 5'h08,
    op_pipe_ctrl = 5'h09,
    op_flush = 5'h0A,
    op_user_intr = 5'h0B,
    op_mem_copy = 5'h0C,
    op_perf_report = 5'h0D,
    op_ctx_set = 5'h0E,
    op_gtt_update = 5'h0F,
    op_display_flip = 5'h10,
    op_arb_on_off = 5'h11,
    op_atomic = 5'h12,
    op_other = 5'h1F
  } cmd_op_e;

  typedef enum logic [2:0] {
    verdict_exec = 3'h1,
    verdict_noop = 3'h2,
    verdict_limit = 3'h4
  } verdict_e;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_check = 3'b010,
    st_skip = 3'b100
  } filt_state_e;
endpackage

// ### rtl/whitelist_match.sv
/*
  whitelist matcher: hardwired non-privileged list plus programmable entries.
  assumes entries are written by the filter; offsets compared at full width.
*/
`include "cmd_priv_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module whitelist_match #(
  parameter int ENTRIES = `PWL_ENTRIES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [`REG_OFFS_W-1:0] wr_offs,
  input wire logic wr_kernel,
  input wire logic wr_valid,
  input wire logic [`REG_OFFS_W-1:0] look_offs,
  output logic hw_hit,
  output logic user_hit,
  output logic kernel_hit
);
  // ****************************************
  // programmable entries
  // ****************************************
  logic [`REG_OFFS_W-1:0] offs_r [ENTRIES];
  logic [ENTRIES-1:0] kern_r;
  logic [ENTRIES-1:0] valid_r;
  logic [ENTRIES-1:0] u_vec;
  logic [ENTRIES-1:0] k_vec;

  // power-context storage; only cleared by a full reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        offs_r[i] <= '0;
      end
      kern_r <= '0;
      valid_r <= '0;
    end else if (wr_en && (32'(wr_idx) < ENTRIES)) begin
      offs_r[wr_idx] <= wr_offs;
      kern_r[wr_idx] <= wr_kernel; // user/kernel selector bit
      valid_r[wr_idx] <= wr_valid;
    end
  end

  // full offset compare, split by selector bit
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      u_vec[i] = valid_r[i] && !kern_r[i] && (offs_r[i] == look_offs);
      k_vec[i] = valid_r[i] && kern_r[i] && (offs_r[i] == look_offs);
    end
  end

  assign user_hit = |u_vec;
  assign kernel_hit = |k_vec;
  // hardwired non-privileged list
  assign hw_hit = (look_offs == `HW_WL_0) || (look_offs == `HW_WL_1) ||
                  (look_offs == `HW_WL_2) || (look_offs == `HW_WL_3);
endmodule

`default_nettype wire

// ### rtl/cmd_priv_filter.sv
/*
  command privilege filter inside the command parser: classifies buffers,
  judges each command against buffer privilege and issuing function.
  assumes the parser presents one decoded command at a time with its length,
  and holds it while cmd_valid is high and cmd_ready is low.
*/
`include "cmd_priv_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module cmd_priv_filter #(
  parameter int LEN_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic vf_enable_set,
  output logic vf_enable,
  input wire logic ctx_attr_load,
  input wire logic [5:0] ctx_attr_func,
  input wire logic display_vf,
  input wire logic batch_push,
  input wire logic batch_global,
  input wire logic batch_pop,
  input wire logic [3:0] batch_depth_in,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cmd_priv_pkg::cmd_op_e cmd_op,
  input wire logic [LEN_W-1:0] cmd_len,
  input wire logic cmd_global,
  input wire logic cmd_global2,
  input wire logic cmd_index,
  input wire logic cmd_reg_wr,
  input wire logic [`REG_OFFS_W-1:0] cmd_reg_offs,
  input wire logic cmd_notify,
  output cmd_priv_pkg::verdict_e verdict,
  output logic verdict_valid,
  output logic flush_out,
  output logic [LEN_W-1:0] skip_len,
  output logic guc_intr,
  output logic pf_intr,
  input wire logic ctx_switch,
  output logic csb_update,
  input wire logic display_event,
  output logic display_to_pf,
  input wire logic pwl_wr,
  input wire logic pwl_wr_by_pf,
  input wire logic [3:0] pwl_idx,
  input wire logic [`REG_OFFS_W-1:0] pwl_offs,
  input wire logic pwl_kernel,
  input wire logic pwl_valid,
  output logic [3:0] nest_level,
  output logic buf_priv
);
  // ****************************************
  // function and buffer privilege state
  // ****************************************
  logic vf_enable_r;
  logic [5:0] func_r;
  logic is_vf;
  logic priv_r;
  logic [15:0] priv_stack_r;
  logic [3:0] depth_r;
  logic batch_priv_nxt;

  // conventional reset leaves no virtual function
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vf_enable_r <= 1'b0;
      func_r <= 6'h00;
    end else begin
      if (vf_enable_set) vf_enable_r <= 1'b1;
      if (ctx_attr_load) func_r <= ctx_attr_func; // issuing function from attribute
    end
  end

  assign is_vf = vf_enable_r && (func_r != 6'h00);
  assign vf_enable = vf_enable_r;

  // global table => privileged; child limited by parent
  assign batch_priv_nxt = batch_global && priv_r;

  // ring level is privileged; stack holds parent levels
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      priv_r <= 1'b1;
      priv_stack_r <= 16'h0000;
      depth_r <= 4'h0;
    end else if (ctx_attr_load) begin
      priv_r <= 1'b1;
      depth_r <= 4'h0;
    end else if (batch_push && depth_r != 4'hF) begin
      priv_stack_r[depth_r] <= priv_r;
      priv_r <= batch_priv_nxt;
      depth_r <= depth_r + 4'h1;
    end else if (batch_pop && depth_r != 4'h0) begin
      priv_r <= priv_stack_r[depth_r - 4'h1];
      depth_r <= depth_r - 4'h1;
    end
  end

  assign nest_level = depth_r;
  assign buf_priv = priv_r;

  // ****************************************
  // register whitelist
  // ****************************************
  logic hw_hit;
  logic user_hit;
  logic kernel_hit;
  logic pwl_wr_ok;

  // only PF driver or microcontroller may program the list
  assign pwl_wr_ok = pwl_wr && pwl_wr_by_pf;

  whitelist_match #(.ENTRIES(`PWL_ENTRIES)) u_wl (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(pwl_wr_ok),
    .wr_idx(pwl_idx),
    .wr_offs(pwl_offs),
    .wr_kernel(pwl_kernel),
    .wr_valid(pwl_valid),
    .look_offs(cmd_reg_offs),
    .hw_hit(hw_hit),
    .user_hit(user_hit),
    .kernel_hit(kernel_hit)
  );

  logic is_perf_obs;
  logic in_engine;
  logic in_arb;
  logic in_disp;
  logic user_ok;
  logic vf_kern_ok;
  logic reg_ok;

  assign is_perf_obs = cmd_reg_offs == `PERF_OBS_CTRL_OFFS;
  assign in_engine = (cmd_reg_offs & `ENGINE_MMIO_MASK) == `ENGINE_MMIO_BASE;
  assign in_arb = (cmd_reg_offs & `ARB_UNIT_MASK) == `ARB_UNIT_BASE;
  assign in_disp = (cmd_reg_offs & `DISPLAY_MASK) == `DISPLAY_BASE;
  // perf observation control excluded from the user list
  assign user_ok = (hw_hit || user_hit) && !is_perf_obs;
  // VF kernel: user list, kernel entries, own engine only where listed, arbiter, display
  assign vf_kern_ok = user_ok || (kernel_hit && !is_perf_obs) ||
                      (in_engine && (hw_hit || kernel_hit) && !is_perf_obs)
                      || in_arb
                      || (display_vf && in_disp);

  // PF kernel reaches all unprivileged only user list
  assign reg_ok = !priv_r ? user_ok : (is_vf ? vf_kern_ok : 1'b1);

  // ****************************************
  // command verdict
  // ****************************************
  cmd_priv_pkg::verdict_e verdict_nxt;
  logic flush_nxt;
  logic guc_nxt;
  logic pf_int_nxt;

  always_comb begin
    verdict_nxt = cmd_priv_pkg::verdict_exec;
    flush_nxt = 1'b0;
    guc_nxt = 1'b0;
    pf_int_nxt = 1'b0;
    unique case (cmd_op)
      cmd_priv_pkg::op_reg_load_imm, cmd_priv_pkg::op_reg_load_reg: begin
        if (!reg_ok) verdict_nxt = cmd_priv_pkg::verdict_noop;
      end
      cmd_priv_pkg::op_reg_load_mem: begin
        if ((!priv_r && cmd_global) || !reg_ok) begin
          verdict_nxt = cmd_priv_pkg::verdict_noop;
        end
      end
      cmd_priv_pkg::op_reg_store_mem, cmd_priv_pkg::op_store_imm, cmd_priv_pkg::op_atomic,
      cmd_priv_pkg::op_semaphore: begin
        // an unprivileged store, atomic or semaphore stays off the global table
        if (!priv_r && cmd_global) verdict_nxt = cmd_priv_pkg::verdict_noop;
      end
      cmd_priv_pkg::op_indexed_store, cmd_priv_pkg::op_flush: begin
        if ((!priv_r && (cmd_global || cmd_index)) || (cmd_index && cmd_global && is_vf)) begin
          verdict_nxt = cmd_priv_pkg::verdict_noop;
        end
      end
      cmd_priv_pkg::op_pipe_ctrl: begin
        flush_nxt = 1'b1;
        if ((cmd_reg_wr && !reg_ok) || (!priv_r && (cmd_global || cmd_index)) ||
            (cmd_index && cmd_global && is_vf)) begin
          verdict_nxt = cmd_priv_pkg::verdict_limit;
        end
        guc_nxt = cmd_notify && is_vf;
        pf_int_nxt = cmd_notify && !is_vf;
      end
      cmd_priv_pkg::op_user_intr: begin
        guc_nxt = is_vf;
        pf_int_nxt = !is_vf;
      end
      cmd_priv_pkg::op_mem_copy: begin
        if (!priv_r && (cmd_global || cmd_global2)) begin
          verdict_nxt = cmd_priv_pkg::verdict_noop;
        end
      end
      cmd_priv_pkg::op_perf_report: begin
        if (cmd_global && (is_vf || !priv_r)) verdict_nxt = cmd_priv_pkg::verdict_noop;
      end
      cmd_priv_pkg::op_ctx_set: begin
        if (!priv_r) verdict_nxt = cmd_priv_pkg::verdict_noop;
      end
      cmd_priv_pkg::op_gtt_update, cmd_priv_pkg::op_display_flip,
      cmd_priv_pkg::op_arb_on_off: begin
        if (!priv_r || is_vf) verdict_nxt = cmd_priv_pkg::verdict_noop;
      end
      default: verdict_nxt = cmd_priv_pkg::verdict_exec;
    endcase
  end

  // ****************************************
  // verdict handshake
  // ****************************************
  cmd_priv_pkg::filt_state_e state_r;
  cmd_priv_pkg::filt_state_e state_nxt;
  cmd_priv_pkg::verdict_e verdict_r;
  logic [LEN_W-1:0] skip_len_r;
  logic flush_r;
  logic guc_r;
  logic pf_int_r;

  // one verdict per command, then a cycle to consume it
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cmd_priv_pkg::st_idle: if (cmd_valid) state_nxt = cmd_priv_pkg::st_check;
      cmd_priv_pkg::st_check: state_nxt = cmd_priv_pkg::st_skip;
      cmd_priv_pkg::st_skip: state_nxt = cmd_priv_pkg::st_idle;
      default: state_nxt = cmd_priv_pkg::st_idle;
    endcase
  end

  assign cmd_ready = state_r == cmd_priv_pkg::st_skip;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= cmd_priv_pkg::st_idle;
      verdict_r <= cmd_priv_pkg::verdict_exec;
      skip_len_r <= '0;
      flush_r <= 1'b0;
      guc_r <= 1'b0;
      pf_int_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      flush_r <= 1'b0;
      guc_r <= 1'b0;
      pf_int_r <= 1'b0;
      if (state_r == cmd_priv_pkg::st_check) begin
        verdict_r <= verdict_nxt; // compare precedes any write
        skip_len_r <= cmd_len; // full length consumed even on no-op
        flush_r <= flush_nxt;
        guc_r <= guc_nxt;
        pf_int_r <= pf_int_nxt;
      end
    end
  end

  assign verdict = verdict_r;
  assign verdict_valid = cmd_ready;
  assign skip_len = skip_len_r;
  assign flush_out = flush_r;
  assign guc_intr = guc_r;
  assign pf_intr = pf_int_r;

  // ****************************************
  // status page and display events
  // ****************************************
  logic csb_r;
  logic disp_r;

  // status page interrupt writes assume software keeps them masked
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csb_r <= 1'b0;
      disp_r <= 1'b0;
    end else begin
      csb_r <= ctx_switch && !is_vf;
      disp_r <= display_event; // PF only; microcontroller may forward
    end
  end

  assign csb_update = csb_r;
  assign display_to_pf = disp_r;

  // ****************************************
  // checks
  // ****************************************
  a_child_priv_limit: assert property (@(posedge ref_clk) disable iff (rst)
    (batch_push && depth_r != 4'hF && !ctx_attr_load && !priv_r) |=> !priv_r)
    else $error("child buffer gained privilege");
  a_perf_obs_block: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == cmd_priv_pkg::st_check && cmd_op == cmd_priv_pkg::op_reg_load_imm
     && is_perf_obs && (is_vf || !priv_r)) |=> verdict == cmd_priv_pkg::verdict_noop)
    else $error("perf observation write not blocked");
  a_vf_index_noop: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == cmd_priv_pkg::st_check && cmd_op == cmd_priv_pkg::op_indexed_store
     && cmd_index && cmd_global && is_vf) |=> verdict == cmd_priv_pkg::verdict_noop)
    else $error("VF global index write allowed");
  a_copy_noop: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == cmd_priv_pkg::st_check && cmd_op == cmd_priv_pkg::op_mem_copy
     && !priv_r && cmd_global2) |=> verdict == cmd_priv_pkg::verdict_noop)
    else $error("unprivileged global copy allowed");
  a_pipe_flush: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == cmd_priv_pkg::st_check && cmd_op == cmd_priv_pkg::op_pipe_ctrl)
    |=> flush_out ##1 !flush_out)
    else $error("pipe control flush lost");
  a_user_intr_guc: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == cmd_priv_pkg::st_check && cmd_op == cmd_priv_pkg::op_user_intr && is_vf)
    |=> guc_intr && !pf_intr)
    else $error("VF user interrupt misrouted");
  a_csb_pf_only: assert property (@(posedge ref_clk) disable iff (rst)
    (ctx_switch && is_vf && !$past(ctx_attr_load)) |=> !csb_update)
    else $error("status buffer updated on VF switch");
  a_len_consumed: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == cmd_priv_pkg::st_check) |=> cmd_ready && skip_len == $past(cmd_len))
    else $error("command length not consumed");
  a_ctx_set_block: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == cmd_priv_pkg::st_check && cmd_op == cmd_priv_pkg::op_ctx_set && !priv_r)
    |=> verdict == cmd_priv_pkg::verdict_noop)
    else $error("context set in unprivileged buffer");
  a_perf_report_vf: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == cmd_priv_pkg::st_check && cmd_op == cmd_priv_pkg::op_perf_report
     && cmd_global && is_vf) |=> verdict == cmd_priv_pkg::verdict_noop)
    else $error("VF global perf report allowed");

  c_noop_seen: cover property (@(posedge ref_clk) disable iff (rst)
    verdict_valid && verdict == cmd_priv_pkg::verdict_noop);
  c_limit_seen: cover property (@(posedge ref_clk) disable iff (rst)
    verdict_valid && verdict == cmd_priv_pkg::verdict_limit);
  c_nested: cover property (@(posedge ref_clk) disable iff (rst) depth_r == 4'h2);
  c_vf_guc: cover property (@(posedge ref_clk) disable iff (rst) guc_intr);
endmodule

`default_nettype wire

// ### sim/cmd_source.sv
/*
  command source model: presents one decoded command and holds it until taken.
  assumes the filter answers with cmd_ready; one clock, async high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module cmd_source #(
  parameter int LEN_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic go,
  input wire cmd_priv_pkg::cmd_op_e op,
  input wire logic [LEN_W-1:0] len,
  input wire logic [4:0] flags,
  input wire logic [22:0] offs,
  output logic cmd_valid,
  output cmd_priv_pkg::cmd_op_e cmd_op,
  output logic [LEN_W-1:0] cmd_len,
  output logic cmd_global,
  output logic cmd_global2,
  output logic cmd_index,
  output logic cmd_reg_wr,
  output logic cmd_notify,
  output logic [22:0] cmd_reg_offs,
  input wire logic cmd_ready,
  input wire cmd_priv_pkg::verdict_e verdict,
  input wire logic flush_out,
  input wire logic guc_intr,
  input wire logic pf_intr,
  input wire logic [LEN_W-1:0] skip_len,
  output logic done,
  output logic [5:0] got,
  output logic [LEN_W-1:0] got_len
);
  logic [4:0] fl_r;
  assign {cmd_global, cmd_global2, cmd_index, cmd_reg_wr, cmd_notify} = fl_r;
  // ************************************************************
  // hold until taken, then scramble: a dropped command must not look live
  // ************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      done <= 1'b0;
      fl_r <= 5'h00;
      cmd_op <= cmd_priv_pkg::op_noop;
      cmd_len <= '0;
      cmd_reg_offs <= 23'h000000;
      got <= 6'h00;
      got_len <= '0;
    end else if (cmd_valid && cmd_ready) begin
      cmd_valid <= 1'b0;
      done <= 1'b1;
      got <= {verdict, flush_out, guc_intr, pf_intr};
      got_len <= skip_len;
      fl_r <= ~fl_r;
      cmd_op <= cmd_priv_pkg::cmd_op_e'(~cmd_op);
      cmd_len <= ~cmd_len;
      cmd_reg_offs <= ~cmd_reg_offs;
    end else begin
      done <= 1'b0;
      if (go && !cmd_valid) begin
        cmd_valid <= 1'b1;
        fl_r <= flags;
        cmd_op <= op;
        cmd_len <= len;
        cmd_reg_offs <= offs;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/virt_command_privilege_filter_test.sv
/*
  self-checking bench for the command privilege filter.
  assumes the command source model and the filter's three-cycle answer.
*/
`include "cmd_priv_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module virt_command_privilege_filter_test;
  localparam logic [2:0] v_ex = cmd_priv_pkg::verdict_exec;
  localparam logic [2:0] v_no = cmd_priv_pkg::verdict_noop;
  localparam logic [2:0] v_lim = cmd_priv_pkg::verdict_limit;
  localparam cmd_priv_pkg::cmd_op_e ld = cmd_priv_pkg::op_reg_load_imm;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic vf_enable_set = 1'b0, ctx_attr_load = 1'b0, display_vf = 1'b0, batch_push = 1'b0;
  logic batch_global = 1'b0, batch_pop = 1'b0, ctx_switch = 1'b0, display_event = 1'b0;
  logic pwl_wr = 1'b0, pwl_wr_by_pf = 1'b0, pwl_kernel = 1'b0, pwl_valid = 1'b0, go = 1'b0;
  logic [5:0] ctx_attr_func = 6'h00;
  logic [3:0] pwl_idx = 4'h0;
  logic [22:0] pwl_offs = 23'h000000, offs = 23'h000000, cmd_reg_offs;
  logic [7:0] len = 8'h00, cmd_len, skip_len, got_len;
  logic [4:0] flags = 5'h00;
  cmd_priv_pkg::cmd_op_e op = cmd_priv_pkg::op_noop, cmd_op;
  cmd_priv_pkg::verdict_e verdict;
  logic vf_enable, cmd_valid, cmd_ready, cmd_global, cmd_global2, cmd_index, cmd_reg_wr;
  logic cmd_notify, flush_out, guc_intr, pf_intr, csb_update, display_to_pf, buf_priv, done;
  logic [3:0] nest_level;
  logic verdict_valid;
  logic [5:0] got;
  int error_cnt = 0;
  int checks = 0;

  always #4 ref_clk = ~ref_clk;

  cmd_priv_filter #(.LEN_W(8)) i_cmd_priv_filter (
    .ref_clk, .rst, .vf_enable_set, .vf_enable, .ctx_attr_load, .ctx_attr_func, .display_vf,
    .batch_push, .batch_global, .batch_pop, .batch_depth_in(4'h0), .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_len, .cmd_global, .cmd_global2, .cmd_index, .cmd_reg_wr, .cmd_reg_offs,
    .cmd_notify, .verdict, .verdict_valid, .flush_out, .skip_len, .guc_intr, .pf_intr,
    .ctx_switch, .csb_update, .display_event, .display_to_pf, .pwl_wr, .pwl_wr_by_pf, .pwl_idx,
    .pwl_offs, .pwl_kernel, .pwl_valid, .nest_level, .buf_priv
  );

  cmd_source #(.LEN_W(8)) i_cmd_source (
    .ref_clk, .rst, .go, .op, .len, .flags, .offs, .cmd_valid, .cmd_op, .cmd_len, .cmd_global,
    .cmd_global2, .cmd_index, .cmd_reg_wr, .cmd_notify, .cmd_reg_offs, .cmd_ready, .verdict,
    .flush_out, .guc_intr, .pf_intr, .skip_len, .done, .got, .got_len
  );

  // ************************************************************
  // compare and report
  // ************************************************************
  task automatic bad(input logic [22:0] g, input logic [22:0] e);
    error_cnt++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
  endtask
  task automatic chk_v(input logic [2:0] g, input logic [2:0] e);
    checks++;
    if (g !== e) bad(23'(g), 23'(e));
  endtask
  task automatic chk_b(input logic g, input logic e);
    checks++;
    if (g !== e) bad(23'(g), 23'(e));
  endtask
  task automatic chk_n(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) bad(23'(g), 23'(e));
  endtask
  task automatic results;
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ************************************************************
  // drivers
  // ************************************************************
  // len stepped each command so a stale skip length cannot match
  task automatic run(input cmd_priv_pkg::cmd_op_e o, input logic [22:0] a, input logic [4:0] f,
                     input logic [2:0] ev, input logic [2:0] ep);
    int n;
    int seen;
    n = 0;
    seen = 0;
    @(posedge ref_clk);
    go <= 1'b1;
    op <= o;
    offs <= a;
    flags <= f;
    len <= len + 8'h03;
    @(posedge ref_clk);
    go <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
      if (verdict_valid === 1'b1) seen++;
    end while (done !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      results();
    end
    chk_v(got[5:3], ev);
    chk_v(got[2:0], ep);
    chk_n(8'(seen), 8'h01);
    if (ev == v_no) chk_n(got_len, len);
  endtask
  task automatic batch(input logic psh, input logic g, input logic [3:0] lvl, input logic pr);
    @(posedge ref_clk);
    batch_push <= psh;
    batch_pop <= ~psh;
    batch_global <= g;
    @(posedge ref_clk);
    batch_push <= 1'b0;
    batch_pop <= 1'b0;
    @(posedge ref_clk);
    chk_n({4'h0, nest_level}, {4'h0, lvl});
    chk_b(buf_priv, pr);
  endtask
  task automatic func_set(input logic [5:0] fn);
    @(posedge ref_clk);
    ctx_attr_load <= 1'b1;
    ctx_attr_func <= fn;
    @(posedge ref_clk);
    ctx_attr_load <= 1'b0;
    @(posedge ref_clk);
    chk_b(buf_priv, 1'b1);
  endtask
  task automatic pwl(input logic pf, input logic [3:0] ix, input logic [22:0] a, input logic k);
    @(posedge ref_clk);
    pwl_wr <= 1'b1;
    pwl_wr_by_pf <= pf;
    pwl_idx <= ix;
    pwl_offs <= a;
    pwl_kernel <= k;
    pwl_valid <= 1'b1;
    @(posedge ref_clk);
    pwl_wr <= 1'b0;
  endtask
  // the source never unmasks a status page interrupt
  task automatic evt(input logic csb);
    @(posedge ref_clk);
    ctx_switch <= 1'b1;
    display_event <= 1'b1;
    @(posedge ref_clk);
    ctx_switch <= 1'b0;
    display_event <= 1'b0;
    @(posedge ref_clk);
    chk_b(csb_update, csb);
    chk_b(display_to_pf, 1'b1);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_pf_ring;
    func_set(6'h00);
    run(ld, `PERF_OBS_CTRL_OFFS, 5'h00, v_ex, 3'b000);
    run(ld, 23'h003000, 5'h00, v_ex, 3'b000);
    run(cmd_priv_pkg::op_user_intr, 23'h0, 5'h00, v_ex, 3'b001);
    run(cmd_priv_pkg::op_indexed_store, 23'h0, 5'h14, v_ex, 3'b000);
    run(cmd_priv_pkg::op_perf_report, 23'h0, 5'h10, v_ex, 3'b000);
    evt(1'b1);
  endtask
  task automatic t_unpriv;
    batch(1'b1, 1'b0, 4'h1, 1'b0);
    batch(1'b1, 1'b1, 4'h2, 1'b0);
    run(cmd_priv_pkg::op_reg_load_mem, `HW_WL_0, 5'h10, v_no, 3'b000);
    run(ld, `HW_WL_0, 5'h00, v_ex, 3'b000);
    run(ld, `PERF_OBS_CTRL_OFFS, 5'h00, v_no, 3'b000);
    run(cmd_priv_pkg::op_mem_copy, 23'h0, 5'h08, v_no, 3'b000);
    run(cmd_priv_pkg::op_pipe_ctrl, 23'h003000, 5'h02, v_lim, 3'b100);
    run(cmd_priv_pkg::op_ctx_set, 23'h0, 5'h00, v_no, 3'b000);
    run(cmd_priv_pkg::op_perf_report, 23'h0, 5'h10, v_no, 3'b000);
    pwl(1'b1, 4'h0, 23'h003100, 1'b0);
    run(ld, 23'h003100, 5'h00, v_ex, 3'b000);
    run(ld, 23'h003104, 5'h00, v_no, 3'b000);
    pwl(1'b1, 4'hC, 23'h003200, 1'b0);
    run(ld, 23'h003200, 5'h00, v_no, 3'b000);
    batch(1'b0, 1'b0, 4'h1, 1'b0);
    batch(1'b0, 1'b0, 4'h0, 1'b1);
  endtask
  task automatic t_vf;
    @(posedge ref_clk);
    vf_enable_set <= 1'b1;
    @(posedge ref_clk);
    vf_enable_set <= 1'b0;
    func_set(6'h01);
    chk_b(vf_enable, 1'b1);
    run(ld, `PERF_OBS_CTRL_OFFS, 5'h00, v_no, 3'b000);
    run(ld, 23'h004010, 5'h00, v_ex, 3'b000);
    run(ld, 23'h002100, 5'h00, v_no, 3'b000);
    pwl(1'b0, 4'h5, 23'h002100, 1'b1);
    run(ld, 23'h002100, 5'h00, v_no, 3'b000);
    pwl(1'b1, 4'hB, 23'h002100, 1'b1);
    run(ld, 23'h002100, 5'h00, v_ex, 3'b000);
    run(cmd_priv_pkg::op_reg_store_mem, `HW_WL_0, 5'h10, v_ex, 3'b000);
    run(cmd_priv_pkg::op_indexed_store, 23'h0, 5'h14, v_no, 3'b000);
    run(cmd_priv_pkg::op_indexed_store, 23'h0, 5'h04, v_ex, 3'b000);
    run(cmd_priv_pkg::op_flush, 23'h0, 5'h14, v_no, 3'b000);
    run(cmd_priv_pkg::op_semaphore, 23'h0, 5'h10, v_ex, 3'b000);
    run(cmd_priv_pkg::op_user_intr, 23'h0, 5'h00, v_ex, 3'b010);
    run(cmd_priv_pkg::op_pipe_ctrl, 23'h003000, 5'h03, v_lim, 3'b110);
    run(cmd_priv_pkg::op_perf_report, 23'h0, 5'h10, v_no, 3'b000);
    run(cmd_priv_pkg::op_ctx_set, 23'h0, 5'h00, v_ex, 3'b000);
    run(ld, 23'h060010, 5'h00, v_no, 3'b000);
    display_vf <= 1'b1;
    run(ld, 23'h060010, 5'h00, v_ex, 3'b000);
    display_vf <= 1'b0;
    evt(1'b0);
  endtask
  task automatic t_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk_b(vf_enable, 1'b0);
    chk_b(buf_priv, 1'b1);
    chk_n({4'h0, nest_level}, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk_b(vf_enable, 1'b0);
    chk_b(buf_priv, 1'b1);
    t_pf_ring();
    t_unpriv();
    t_vf();
    t_reset();
    results();
  end
endmodule
`default_nettype wire
